// *** core/qrp_consts.vh ***
// Overview of operation
// - Single-rate command EBh uses 3 or 4 address bytes per width bit; ECh always 4.
// - Double-rate command EDh uses 3 or 4 address bytes per width bit; EEh always 4.
// - Four-line read commands are accepted only while the quad enable bit is 1.
// - Single-rate reads sample address one nibble per rising serial clock edge.
// - Latency cycles from the latency field follow the mode bits; inputs ignored.
// - Single-rate read data leaves one nibble per clock on the falling edge.
// - Read address increments per byte and wraps to zero after the top address.
// - Single-rate mode upper nibble Ah keeps continuous read; next access starts with address.
// - Other single-rate mode values leave continuous read at chip select rise; also mode reset.
// - Single-rate mode byte takes two clocks right after the last address clock.
// - Four-lane command mode sends the instruction one nibble per rising edge.
// - Double-rate reads take address and give data on both clock edges.
// - Complementary double-rate mode nibbles enter continuous double-rate read.
// - Non-complementary nibbles leave it at the next chip select cycle; also mode reset.
// - With the learning pattern on, the device drives up to the last four dummy cycles of double-rate reads only; host stays off.
// - The preamble fills up to four clocks right before the first double-rate data, all dummy clocks when latency is below four.
// - The eight-bit learning pattern goes out identically on all four lines.
`ifndef QRP_CONSTS_VH
`define QRP_CONSTS_VH

// -----------------------------------------------------------------
// Instruction codes
// -----------------------------------------------------------------
`define QRP_CMD_SDR 8'hEB
`define QRP_CMD_SDR_WIDE 8'hEC
`define QRP_CMD_DDR 8'hED
`define QRP_CMD_DDR_WIDE 8'hEE

// -----------------------------------------------------------------
// Sequence counts and mode values
// -----------------------------------------------------------------
`define QRP_CMD_BITS_LAST 4'h7
`define QRP_CMD_NIBS_LAST 4'h1
`define QRP_ADDR_NIBS_LAST_NARROW 4'h5
`define QRP_ADDR_NIBS_LAST_WIDE 4'h7
`define QRP_MODE_SDR_LAST 4'h1
`define QRP_MODE_KEEP_NIB 4'hA
`define QRP_PREAMBLE_CYCLES 4'h4

// -----------------------------------------------------------------
// Reset values
// -----------------------------------------------------------------
`define QRP_RST_ADDR 32'h0000_0000
`define QRP_RST_BYTE 8'h00
`define QRP_RST_NIB 4'h0

`endif

// *** core/qrp_fifo.v ***
`timescale 1ns/10ps
module qrp_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
)
(
    // Clock and reset.
    input wire clk,
    input wire rstn,
    input wire clear,
    // Filling side.
    input wire inValid,
    input wire [WIDTH-1:0] inData,
    output reg inReady_ff,
    // Draining side.
    output reg outValid_ff,
    output reg [WIDTH-1:0] outData_ff,
    input wire outReady
);

    // -----------------------------------------------------------------
    // Storage and pointers
    // -----------------------------------------------------------------
    localparam [AW:0] FULL_CNT = DEPTH[AW:0];

    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] wrPtr_ff;
    reg [AW-1:0] rdPtr_ff;
    reg [AW:0] count_ff;
    wire push;
    wire pop;
    wire [AW-1:0] nxt_rdPtr;
    wire [AW:0] nxt_count;

    // Ready and valid are registered flags, so both stay honest.
    assign push = inValid & inReady_ff;
    assign pop = outReady & outValid_ff;
    assign nxt_rdPtr = pop ? rdPtr_ff + {{(AW-1){1'b0}}, 1'b1} : rdPtr_ff;
    assign nxt_count = clear ? {(AW+1){1'b0}} :
        count_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

    // The array itself needs no reset.
    always @(posedge clk)
    begin
        if (push)
            mem[wrPtr_ff] <= inData;
    end

    // Head word is held in a register; a word written into the head slot is bypassed.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPtr_ff <= {AW{1'b0}};
            rdPtr_ff <= {AW{1'b0}};
            count_ff <= {(AW+1){1'b0}};
            inReady_ff <= 1'b1;
            outValid_ff <= 1'b0;
            outData_ff <= {WIDTH{1'b0}};
        end
        else
        begin
            count_ff <= nxt_count;
            inReady_ff <= (nxt_count != FULL_CNT);
            outValid_ff <= (nxt_count != {(AW+1){1'b0}});
            if (clear)
            begin
                wrPtr_ff <= {AW{1'b0}};
                rdPtr_ff <= {AW{1'b0}};
            end
            else
            begin
                if (push)
                    wrPtr_ff <= wrPtr_ff + {{(AW-1){1'b0}}, 1'b1};
                rdPtr_ff <= nxt_rdPtr;
                if (push && (wrPtr_ff == nxt_rdPtr))
                    outData_ff <= inData;
                else
                    outData_ff <= mem[nxt_rdPtr];
            end
        end
    end

endmodule

// *** core/qrp_read_path.v ***
`timescale 1ns/10ps
`include "qrp_consts.vh"
module qrp_read_path #(
    parameter MEM_AW = 32,
    parameter FIFO_DEPTH = 16,
    parameter FIFO_AW = 4
)
(
    // Clock and reset.
    input wire clk,
    input wire rstn,
    // Serial link pins, asynchronous to clk.
    input wire csN,
    input wire sclk,
    input wire [3:0] ioIn,
    output reg [3:0] ioOut_ff,
    output reg [3:0] ioOe_ff,
    // Configuration, from logic on clk.
    input wire quadEnable,
    input wire addrWide,
    input wire fourLaneCmdMode,
    input wire [3:0] latencyCycles,
    input wire learnEnable,
    input wire [7:0] learnPattern,
    input wire modeResetReq,
    // Array fetch port.
    output reg [31:0] fetchAddr_ff,
    output reg fetchReq_ff,
    input wire [7:0] memData,
    input wire memValid,
    output wire memReady,
    // Status.
    output reg contSdr_ff,
    output reg contDdr_ff,
    output reg busy_ff
);

    // -----------------------------------------------------------------
    // Local definitions
    // -----------------------------------------------------------------
    localparam [2:0] ST_IDLE = 3'b000;
    localparam [2:0] ST_CMD = 3'b001;
    localparam [2:0] ST_ADDR = 3'b010;
    localparam [2:0] ST_MODE = 3'b011;
    localparam [2:0] ST_DUMMY = 3'b100;
    localparam [2:0] ST_DATA = 3'b101;
    localparam [2:0] ST_SKIP = 3'b110;
    localparam [31:0] ADDR_MASK = {32{1'b1}} >> (32 - MEM_AW);

    // Decode an instruction into {accepted, double rate, four-byte address}.
    function [2:0] decode;
        input [7:0] code;
        input quadOk;
        input wideBit;
        begin
            decode = 3'b000;
            if (quadOk)
            begin
                case (code)
                    `QRP_CMD_SDR: decode = {1'b1, 1'b0, wideBit};
                    `QRP_CMD_SDR_WIDE: decode = 3'b101;
                    `QRP_CMD_DDR: decode = {1'b1, 1'b1, wideBit};
                    `QRP_CMD_DDR_WIDE: decode = 3'b111;
                    default: decode = 3'b000;
                endcase
            end
        end
    endfunction

    // Pick one pattern bit, used at rising and falling edges alike.
    function learnBit;
        input [7:0] pattern;
        input [3:0] idx;
        begin
            learnBit = pattern[idx[2:0]];
        end
    endfunction

    // -----------------------------------------------------------------
    // Pin synchronisers
    // -----------------------------------------------------------------
    reg [5:0] sync1_ff;
    reg [5:0] sync2_ff;
    reg [5:0] sync3_ff;
    reg [5:0] pin_ff;
    wire [5:0] nxt_pin;
    wire [5:0] pinRaw;
    genvar g;

    assign pinRaw = {csN, sclk, ioIn};

    // A pin level is accepted only once the second and third stages agree.
    generate
        for (g = 0; g < 6; g = g + 1)
        begin : gSync
            assign nxt_pin[g] = (sync2_ff[g] == sync3_ff[g]) ? sync3_ff[g] : pin_ff[g];
        end
    endgenerate

    // Three stages plus the filtered level; all reset to idle bus values.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sync1_ff <= 6'h20;
            sync2_ff <= 6'h20;
            sync3_ff <= 6'h20;
            pin_ff <= 6'h20;
        end
        else
        begin
            sync1_ff <= pinRaw;
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
            pin_ff <= nxt_pin;
        end
    end

    // Edge events act in the cycle in which the filtered level changes.
    wire csFall = pin_ff[5] & ~nxt_pin[5];
    wire csRise = ~pin_ff[5] & nxt_pin[5];
    wire csLow = ~nxt_pin[5];
    wire sckRise = ~pin_ff[4] & nxt_pin[4];
    wire sckFall = pin_ff[4] & ~nxt_pin[4];
    wire [3:0] nib = nxt_pin[3:0];

    // -----------------------------------------------------------------
    // Sequencer state
    // -----------------------------------------------------------------
    reg [2:0] state_ff;
    reg [3:0] cnt_ff;
    reg [7:0] cmd_ff;
    reg [31:0] addr_ff;
    reg ddr_ff;
    reg wide_ff;
    reg contWide_ff;
    reg [3:0] modeHi_ff;
    reg modeSeen_ff;
    reg keep_ff;
    reg ddrExit_ff;
    reg half_ff;
    reg fifoClr_ff;
    wire [2:0] cmdKind;
    wire [7:0] nxt_cmd;
    wire [31:0] nxt_addr;
    wire [3:0] cntInc;
    wire [3:0] leftFall;
    wire [3:0] leftRise;
    wire dataEdge;
    wire pop;
    wire fifoValid;
    wire [7:0] fifoData;

    assign nxt_cmd = fourLaneCmdMode ? {cmd_ff[3:0], nib} : {cmd_ff[6:0], nib[0]};
    assign cmdKind = decode(nxt_cmd, quadEnable, addrWide);
    assign nxt_addr = {addr_ff[27:0], nib};
    assign cntInc = cnt_ff + 4'h1;
    // Cycles of latency still to come, seen from a falling or a rising edge.
    assign leftFall = latencyCycles - cnt_ff;
    assign leftRise = latencyCycles - cntInc;
    assign dataEdge = csLow && (state_ff == ST_DATA) && (sckFall || (ddr_ff && sckRise));
    // A byte leaves the buffer once its low nibble has been driven.
    assign pop = dataEdge & half_ff & fifoValid;

    // -----------------------------------------------------------------
    // Prefetch buffer
    // -----------------------------------------------------------------
    // Bytes are fetched ahead of the serial stream; a full buffer stalls the array.
    qrp_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH),
        .AW(FIFO_AW)
    ) uFifo (
        .clk(clk),
        .rstn(rstn),
        .clear(fifoClr_ff),
        .inValid(memValid & fetchReq_ff & ~fifoClr_ff),
        .inData(memData),
        .inReady_ff(memReady),
        .outValid_ff(fifoValid),
        .outData_ff(fifoData),
        .outReady(pop)
    );

    // -----------------------------------------------------------------
    // Main sequencer
    // -----------------------------------------------------------------
    // One process owns the link state, the continuous read flags and the fetch address.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            state_ff <= ST_IDLE;
            cnt_ff <= `QRP_RST_NIB;
            cmd_ff <= `QRP_RST_BYTE;
            addr_ff <= `QRP_RST_ADDR;
            ddr_ff <= 1'b0;
            wide_ff <= 1'b0;
            contWide_ff <= 1'b0;
            modeHi_ff <= `QRP_RST_NIB;
            modeSeen_ff <= 1'b0;
            keep_ff <= 1'b0;
            ddrExit_ff <= 1'b0;
            half_ff <= 1'b0;
            fifoClr_ff <= 1'b0;
            ioOut_ff <= `QRP_RST_NIB;
            ioOe_ff <= `QRP_RST_NIB;
            fetchAddr_ff <= `QRP_RST_ADDR;
            fetchReq_ff <= 1'b0;
            contSdr_ff <= 1'b0;
            contDdr_ff <= 1'b0;
            busy_ff <= 1'b0;
        end
        else
        begin
            fifoClr_ff <= 1'b0;
            // advance and wrap per byte
            // A byte offered while the buffer clears is refused, so the address holds then.
            if (memValid && memReady && fetchReq_ff && !fifoClr_ff)
                fetchAddr_ff <= (fetchAddr_ff + 32'h0000_0001) & ADDR_MASK;
            if (csRise)
            begin
                // Raising select always ends the access and frees the lines.
                state_ff <= ST_IDLE;
                ioOe_ff <= `QRP_RST_NIB;
                fetchReq_ff <= 1'b0;
                busy_ff <= 1'b0;
                if (modeSeen_ff)
                begin
                    contWide_ff <= wide_ff;
                    if (ddr_ff)
                    begin
                        if (keep_ff)
                            contDdr_ff <= 1'b1;
                        else
                            ddrExit_ff <= 1'b1;
                    end
                    else
                        contSdr_ff <= keep_ff;
                end
            end
            else if (csFall)
            begin
                cnt_ff <= `QRP_RST_NIB;
                addr_ff <= `QRP_RST_ADDR;
                half_ff <= 1'b0;
                modeSeen_ff <= 1'b0;
                busy_ff <= 1'b1;
                if (ddrExit_ff)
                begin
                    // leave after select rise and fall
                    contDdr_ff <= 1'b0;
                    ddrExit_ff <= 1'b0;
                    state_ff <= ST_CMD;
                end
                else if (contDdr_ff || contSdr_ff)
                begin
                    state_ff <= ST_ADDR;
                    ddr_ff <= contDdr_ff;
                    wide_ff <= contWide_ff;
                end
                else
                    state_ff <= ST_CMD;
            end
            else if (csLow && (sckRise || sckFall))
            begin
                case (state_ff)
                    ST_CMD:
                    begin
                        // Modes 0 and 3 both shift on rising edges only.
                        if (sckRise)
                        begin
                            cmd_ff <= nxt_cmd;
                            cnt_ff <= cntInc;
                            if (cnt_ff == (fourLaneCmdMode ? `QRP_CMD_NIBS_LAST : `QRP_CMD_BITS_LAST))
                            begin
                                cnt_ff <= `QRP_RST_NIB;
                                ddr_ff <= cmdKind[1];
                                wide_ff <= cmdKind[0];
                                state_ff <= cmdKind[2] ? ST_ADDR : ST_SKIP;
                            end
                        end
                    end
                    ST_ADDR:
                    begin
                        // falls count only after a rise
                        if (sckRise || (ddr_ff && cnt_ff[0]))
                        begin
                            addr_ff <= nxt_addr;
                            cnt_ff <= cntInc;
                            if (cnt_ff == (wide_ff ? `QRP_ADDR_NIBS_LAST_WIDE : `QRP_ADDR_NIBS_LAST_NARROW))
                            begin
                                cnt_ff <= `QRP_RST_NIB;
                                state_ff <= ST_MODE;
                                fetchAddr_ff <= nxt_addr & ADDR_MASK;
                                fetchReq_ff <= 1'b1;
                                fifoClr_ff <= 1'b1;
                            end
                        end
                    end
                    ST_MODE:
                    begin
                        if (sckRise && (cnt_ff == `QRP_RST_NIB))
                        begin
                            modeHi_ff <= nib;
                            cnt_ff <= cntInc;
                        end
                        else if ((sckRise && !ddr_ff && (cnt_ff == `QRP_MODE_SDR_LAST)) ||
                                 (sckFall && ddr_ff && (cnt_ff == `QRP_MODE_SDR_LAST)))
                        begin
                            modeSeen_ff <= 1'b1;
                            keep_ff <= ddr_ff ? (modeHi_ff == ~nib) : (modeHi_ff == `QRP_MODE_KEEP_NIB);
                            cnt_ff <= `QRP_RST_NIB;
                            state_ff <= (latencyCycles == `QRP_RST_NIB) ? ST_DATA : ST_DUMMY;
                            // preamble may start at this fall
                            if (ddr_ff && learnEnable && (latencyCycles != `QRP_RST_NIB) &&
                                (latencyCycles <= `QRP_PREAMBLE_CYCLES))
                            begin
                                ioOut_ff <= {4{learnBit(learnPattern, {latencyCycles[2:0], 1'b0} - 4'h1)}};
                                ioOe_ff <= 4'hF;
                            end
                        end
                    end
                    ST_DUMMY:
                    begin
                        if (sckRise)
                        begin
                            cnt_ff <= cntInc;
                            if (cntInc == latencyCycles)
                                state_ff <= ST_DATA;
                            if (ddr_ff && learnEnable && (leftRise < `QRP_PREAMBLE_CYCLES))
                            begin
                                ioOut_ff <= {4{learnBit(learnPattern, {leftRise[2:0], 1'b0})}};
                                ioOe_ff <= 4'hF;
                            end
                        end
                        else if (ddr_ff && learnEnable && (leftFall <= `QRP_PREAMBLE_CYCLES) &&
                                 (leftFall != `QRP_RST_NIB))
                        begin
                            ioOut_ff <= {4{learnBit(learnPattern, {leftFall[2:0], 1'b0} - 4'h1)}};
                            ioOe_ff <= 4'hF;
                        end
                    end
                    ST_DATA:
                    begin
                        // High nibble first, then low nibble of the head byte.
                        if (dataEdge)
                        begin
                            ioOut_ff <= half_ff ? fifoData[3:0] : fifoData[7:4];
                            ioOe_ff <= 4'hF;
                            half_ff <= ~half_ff;
                        end
                    end
                    ST_SKIP:
                    begin
                        // Unsupported instruction: stay silent until select rises.
                        ioOe_ff <= `QRP_RST_NIB;
                    end
                    default:
                    begin
                        state_ff <= ST_IDLE;
                    end
                endcase
            end
            // A mode reset wins over an entry at the same select rise; a mode byte seen earlier in the frame still enters at the rise.
            if (modeResetReq)
            begin
                contSdr_ff <= 1'b0;
                contDdr_ff <= 1'b0;
                ddrExit_ff <= 1'b0;
                if (csRise)
                    modeSeen_ff <= 1'b0;
            end
        end
    end

    // The buffer can run dry only if the array is slower than the link; the head byte
    // is then driven stale, which the host cannot detect, so the array must keep up.

endmodule

// *** test/qrp_host.sv ***
`timescale 1ns/10ps
module qrp_host (
    // Link pins toward the block.
    output logic csN,
    output logic sclk,
    output logic [3:0] ioIn,
    // Lines as driven by the block.
    input wire logic [3:0] ioOut
);
    // Select high, clock low: the serial clock stands still between frames.
    initial
    begin
        csN = 1'h1;
        sclk = 1'h0;
        ioIn = 4'h0;
    end
    task automatic sel(input logic v);
        ioIn = ~ioIn;
        #225 csN = v;
        #225;
    endtask
    // Capture point fixed two edges late, kept for all data of a read.
    // A 100 ns half period stays far below both ceilings; the value taken on
    // entry is what the block launched two edges earlier.
    task automatic step(input logic [3:0] v, output logic [3:0] q);
        q = ioOut;
        ioIn = v;
        #50 sclk = ~sclk;
        #50;
    endtask
endmodule

// *** test/qrp_read_path_assertions.sv ***
`timescale 1ns/10ps
module qrp_read_path_assertions (
    // Clock and reset.
    input wire clk,
    input wire rstn,
    // Watched ports.
    input wire quadEnable,
    input wire modeResetReq,
    input wire memValid,
    input wire memReady,
    input wire [3:0] ioOe_ff,
    input wire [31:0] fetchAddr_ff,
    input wire fetchReq_ff,
    input wire contSdr_ff,
    input wire contDdr_ff,
    input wire busy_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // ----------------------------------------
    // Link drive and continuous read flags
    // ----------------------------------------
    a_oe_all_lanes: assert property (ioOe_ff == 4'h0 || ioOe_ff == 4'hF)
        else $error("lane enables differ");
    a_oe_idle_off: assert property (!busy_ff && !$past(busy_ff) |-> ioOe_ff == 4'h0)
        else $error("drive while deselected");
    a_quad_off_quiet: assert property (!quadEnable && !contSdr_ff && !contDdr_ff && busy_ff
        && $past(busy_ff) && $past(ioOe_ff) == 4'h0 |-> ioOe_ff == 4'h0) else $error("drive with quad off");
    a_mode_reset_clears: assert property (modeResetReq |=> !contSdr_ff && !contDdr_ff)
        else $error("mode reset ignored");
    a_cont_at_release: assert property ($rose(contSdr_ff) || $rose(contDdr_ff) |-> ##[0:1] !busy_ff)
        else $error("continuous flag set in frame");
    a_cont_in_frame: assert property (busy_ff && $past(busy_ff) && !$past(modeResetReq)
        |-> contSdr_ff == $past(contSdr_ff)) else $error("single rate flag moved in frame");
    // Fetching stream: one address step per accepted byte, stop at release.
    // The first fetch cycle clears the buffer and takes no byte.
    a_fetch_step: assert property (fetchReq_ff && $past(fetchReq_ff) && memValid && memReady
        |=> !fetchReq_ff || fetchAddr_ff == $past(fetchAddr_ff) + 32'h0000_0001) else $error("fetch step");
    a_fetch_stop: assert property ($fell(busy_ff) |-> ##[0:2] !fetchReq_ff)
        else $error("fetch kept after release");
endmodule
bind qrp_read_path qrp_read_path_assertions u_qrp_read_path_assertions (.clk, .rstn, .quadEnable,
    .modeResetReq, .memValid, .memReady, .ioOe_ff, .fetchAddr_ff, .fetchReq_ff, .contSdr_ff, .contDdr_ff, .busy_ff);

// *** test/test_qrp_read_path.sv ***
`timescale 1ns/10ps
`include "qrp_consts.vh"
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("CHECK FAILED %0t: got %h want %h", $time, g, e); end end
module test_qrp_read_path;
    logic clk = 1'h0, rstn = 1'h0, quadEnable = 1'h1, addrWide = 1'h0, fourLaneCmdMode = 1'h0;
    logic learnEnable = 1'h0, modeResetReq = 1'h0, memValid = 1'h0, oeSeen = 1'h0;
    logic [3:0] latencyCycles = 4'h0;
    logic [7:0] learnPattern = 8'h34, memData = 8'h00;
    wire csN, sclk, memReady, fetchReq_ff, contSdr_ff, contDdr_ff, busy_ff;
    wire [3:0] ioIn, ioOut_ff, ioOe_ff;
    wire [31:0] fetchAddr_ff;
    int num_errors = 0, total_checks = 0;
    logic [3:0] got[$];
    qrp_read_path u_qrp_read_path (.clk, .rstn, .csN, .sclk, .ioIn, .ioOut_ff, .ioOe_ff, .quadEnable,
        .addrWide, .fourLaneCmdMode, .latencyCycles, .learnEnable, .learnPattern, .modeResetReq,
        .fetchAddr_ff, .fetchReq_ff, .memData, .memValid, .memReady, .contSdr_ff, .contDdr_ff, .busy_ff);
    qrp_host u_qrp_host (.csN, .sclk, .ioIn, .ioOut(ioOut_ff));
    initial forever #12.5 clk = ~clk;
    // Array stand-in; the top nibble folds in so a wrap to zero is visible.
    function automatic logic [7:0] memAt(input logic [31:0] a);
        return a[7:0] + {a[31:28], a[31:28]};
    endfunction
    // Always offering keeps the buffer full, so it must refuse.
    always @(negedge clk)
    begin
        memValid <= fetchReq_ff;
        memData <= memAt(fetchAddr_ff);
        if (ioOe_ff !== 4'h0) oeSeen <= 1'h1;
    end
    task automatic run(input logic [3:0] r, input logic [3:0] f);
        logic [3:0] q;
        u_qrp_host.step(r, q);
        got.push_back(q);
        u_qrp_host.step(f, q);
        got.push_back(q);
    endtask
    // One whole frame; the value of edge e is held in got[e + 2].
    task automatic xfer(input logic [7:0] cmd, input logic [31:0] a, input logic [7:0] m,
        input int nb, input logic ddr, input logic useCmd);
        int e0, n, j;
        logic [31:0] ea;
        got.delete();
        u_qrp_host.sel(1'h0);
        for (j = 0; useCmd && j < (fourLaneCmdMode ? 2 : 8); j++)
            run(fourLaneCmdMode ? cmd[7-4*j -: 4] : {3'h0, cmd[7-j]}, 4'h0);
        n = (cmd == `QRP_CMD_SDR_WIDE || cmd == `QRP_CMD_DDR_WIDE || addrWide) ? 8 : 6;
        ea = (n == 8) ? a : {8'h00, a[23:0]};
        for (j = 0; j < n; j += ddr ? 2 : 1)
            run(a[4*(n-j)-1 -: 4], ddr ? a[4*(n-j)-5 -: 4] : ~a[4*(n-j)-1 -: 4]);
        if (ddr) run(m[7:4], m[3:0]);
        else
        begin
            run(m[7:4], ~m[7:4]);
            run(m[3:0], ~m[3:0]);
        end
        e0 = got.size() + 2 * latencyCycles - 1;
        for (j = 0; j < latencyCycles + (ddr ? nb : 2 * nb) + 1; j++) run(4'h5, 4'hA);
        for (j = 0; j < nb; j++)
            `CHK({got[e0+(ddr ? 2*j : 4*j)+2], got[e0+(ddr ? 2*j+1 : 4*j+2)+2]}, memAt(ea + j))
        for (j = 0; ddr && learnEnable && j < 8; j++)
            `CHK(got[e0-6+j], {4{learnPattern[7-j]}})
        u_qrp_host.sel(1'h1);
    endtask
    task automatic t_sdr_plain;
        @(negedge clk) latencyCycles = 4'h2;
        xfer(`QRP_CMD_SDR, 32'hAB12_3456, 8'h00, 3, 1'h0, 1'h1);
        `CHK(contSdr_ff, 1'h0)
        $display("test sdr plain done");
    endtask
    task automatic t_sdr_cont;
        @(negedge clk) latencyCycles = 4'h0;
        xfer(`QRP_CMD_SDR_WIDE, 32'hFFFF_FFFF, 8'hA5, 2, 1'h0, 1'h1);
        `CHK(contSdr_ff, 1'h1)
        @(negedge clk) addrWide = 1'h1;
        xfer(8'h00, 32'h0000_0010, 8'h00, 1, 1'h0, 1'h0);
        `CHK(contSdr_ff, 1'h0)
        $display("test sdr continuous done");
    endtask
    task automatic t_ddr_cont;
        @(negedge clk);
        {fourLaneCmdMode, learnEnable, addrWide, latencyCycles} = {3'h6, 4'h4};
        xfer(`QRP_CMD_DDR_WIDE, 32'h8000_1230, 8'h5A, 2, 1'h1, 1'h1);
        `CHK(contDdr_ff, 1'h1)
        @(negedge clk) addrWide = 1'h1;
        xfer(8'h00, 32'h0000_0FFE, 8'h00, 3, 1'h1, 1'h0);
        `CHK(contDdr_ff, 1'h1)
        @(negedge clk) modeResetReq = 1'h1;
        @(negedge clk) modeResetReq = 1'h0;
        `CHK(contDdr_ff, 1'h0)
        $display("test ddr continuous done");
    endtask
    task automatic t_refused;
        @(negedge clk);
        {quadEnable, fourLaneCmdMode, learnEnable, addrWide, latencyCycles, oeSeen} = {4'h0, 4'h1, 1'h0};
        xfer(`QRP_CMD_SDR, 32'h0012_3456, 8'h00, 0, 1'h0, 1'h1);
        `CHK(oeSeen, 1'h0)
        @(negedge clk) quadEnable = 1'h1;
        addrWide = 1'h1;
        xfer(`QRP_CMD_DDR, 32'h00AB_CDEF, 8'hFF, 2, 1'h1, 1'h1);
        $display("test refused done");
    endtask
    task automatic end_sim;
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    initial
    begin
        repeat (8) @(posedge clk);
        @(negedge clk) rstn = 1'h1;
        repeat (4) @(negedge clk);
        t_sdr_plain();
        t_sdr_cont();
        t_ddr_cont();
        t_refused();
        end_sim();
    end
    // A hang counts as a mismatch.
    initial
    begin
        #400000 num_errors++;
        end_sim();
    end
endmodule
